// ### shared/wwd_pkg.sv
/*
  Constants, option byte layout, timing counts and carrier types of the
  windowed watchdog with access check.
  Assumes a 200 MHz system clock and a 240 kHz low-speed oscillator rate.
*/
package wwd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned LS_OSC_HZ = 240_000;
  localparam int unsigned LS_DIV = CLK_HZ / LS_OSC_HZ;
  localparam logic [9:0] LS_DIV_LAST = 10'(LS_DIV - 1);

  // ----------------------------------------------------------------
  // Boot option byte fields
  // ----------------------------------------------------------------
  localparam logic [15:0] OPT_BYTE_ADDR = 16'h0080;
  localparam int unsigned OPT_EN_BIT = 4;
  localparam int unsigned OPT_OVF_LSB = 1;
  localparam int unsigned OPT_WIN_LSB = 5;

  // ----------------------------------------------------------------
  // Kick key and count limits
  // ----------------------------------------------------------------
  localparam logic [7:0] KICK_KEY = 8'hac;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] OVF_LIMIT [0:7] = '{
    16'h03ff, 16'h07ff, 16'h0fff, 16'h1fff,
    16'h3fff, 16'h7fff, 16'hffff, 16'hffff
  };
  localparam logic [1:0] WIN_OPEN_FULL = 2'h3;

  // ----------------------------------------------------------------
  // Memory map for the access check
  // ----------------------------------------------------------------
  localparam logic [15:0] EXEMPT_A_LO = 16'hfb00;
  localparam logic [15:0] EXEMPT_A_HI = 16'hffcf;
  localparam logic [15:0] EXEMPT_B_LO = 16'hffe0;
  localparam logic [15:0] EXP_RAM_BASE = 16'hf000;
  localparam logic [15:0] HS_RAM_END = 16'hfeff;
  localparam logic [15:0] HS_RAM_CEIL = 16'hff00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    WWD_ST_CFG = 4'b0001,
    WWD_ST_OFF = 4'b0010,
    WWD_ST_RUN = 4'b0100,
    WWD_ST_HIT = 4'b1000
  } wwd_state_e;

  typedef struct packed {
    logic enable;
    logic [1:0] win_sel;
    logic [2:0] ovf_sel;
  } wwd_cfg_s;

  typedef struct packed {
    logic overflow;
    logic window;
    logic bit_op;
    logic bad_key;
    logic fetch;
    logic access;
  } wwd_cause_s;

endpackage : wwd_pkg

// ### logic/wwd_tick_div.sv
/*
  Divider that turns the system clock into one-cycle enable pulses at
  the low-speed oscillator rate.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_div (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  output logic tick_o
);

  logic [9:0] div_reg;

  assign tick_o = run_i && (div_reg == wwd_pkg::LS_DIV_LAST);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg <= 10'h000;
    end else if (!run_i || tick_o) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= div_reg + 10'h001;
    end
  end

endmodule : wwd_tick_div
`default_nettype wire

// ### logic/wwd_top.sv
/*
  Windowed watchdog with illegal fetch and access check. Counts on the
  low-speed rate, is cleared by a key write, and requests an internal
  reset on overflow, misplaced or bad kicks and out-of-map addresses.
  Assumes the CPU side presents strobes synchronous to CLOCK_I and that
  the system answers a reset request by asserting ARST_N_I.
*/
// How it works
// - Option bit 4 enables counter and access check
// - Option bits 3..1 pick the overflow time
// - Option bits 6..5 pick the window period
// - Counting starts by itself after reset release
// - Key ACH clears counter and restarts it
// - Later kicks in closed window cause reset
// - Overflow without valid kick causes reset
// - Bit manipulation on kick register causes reset
// - Any non-key byte written causes reset
// - Fetch outside configured areas causes reset
// - Data access outside areas resets, some exempt
// - First kick after reset ignores window
// - Kick-to-overflow error stays within two ticks
// - Kick just before FFFFH still clears
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] OPTION_BYTE_I,
  input wire logic KICK_WR_I,
  input wire logic [7:0] KICK_WDATA_I,
  input wire logic KICK_BIT_OP_I,
  input wire logic FETCH_I,
  input wire logic [15:0] FETCH_ADDR_I,
  input wire logic ACCESS_I,
  input wire logic [15:0] ACCESS_ADDR_I,
  input wire logic [7:0] INTERNAL_MEMORY_SIZE_I,
  input wire logic [7:0] EXPANSION_RAM_SIZE_I,
  output logic INT_RESET_REQ_O,
  output wwd_pkg::wwd_cause_s RESET_CAUSE_O,
  output logic RUNNING_O,
  output logic [15:0] COUNT_O
);

  // ----------------------------------------------------------------
  // Area decode
  // ----------------------------------------------------------------
  function automatic logic area_ok(input logic [15:0] addr,
                                   input logic [7:0] internal_memory_size_reg,
                                   input logic [7:0] expansion_ram_size_reg);
    logic rom_ok;
    logic hs_ok;
    logic exp_ok;
    logic [15:0] hs_base;
    logic [16:0] exp_top;
    rom_ok = addr <= {internal_memory_size_reg[3:0], 12'hfff};
    hs_base = wwd_pkg::HS_RAM_CEIL - {internal_memory_size_reg[7:4], 8'h00};
    hs_ok = (addr >= hs_base) && (addr <= wwd_pkg::HS_RAM_END);
    // One bit wider so that a large size does not wrap the top
    exp_top = {1'b0, wwd_pkg::EXP_RAM_BASE} + {3'b000, expansion_ram_size_reg[3:0], 10'h000};
    exp_ok = (addr >= wwd_pkg::EXP_RAM_BASE) && ({1'b0, addr} < exp_top);
    return rom_ok || hs_ok || exp_ok;
  endfunction : area_ok

  function automatic logic [15:0] closed_limit(input logic [15:0] lim,
                                               input logic [1:0] sel);
    logic [15:0] res;
    res = 16'h0000;
    case (sel)
      2'h0: res = lim - (lim >> 2);
      2'h1: res = lim >> 1;
      2'h2: res = lim >> 2;
      default: res = 16'h0000;
    endcase
    return res;
  endfunction : closed_limit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wwd_pkg::wwd_state_e state_reg;
  wwd_pkg::wwd_state_e state_next;
  wwd_pkg::wwd_cfg_s cfg_reg;
  wwd_pkg::wwd_cause_s cause_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic kicked_reg;
  logic req_reg;

  wire logic running = (state_reg == wwd_pkg::WWD_ST_RUN);
  wire logic tick;
  wire logic [15:0] ovf_limit = wwd_pkg::OVF_LIMIT[cfg_reg.ovf_sel];
  wire logic [15:0] win_closed = closed_limit(ovf_limit,
                                              cfg_reg.win_sel);
  wire logic in_closed = (cfg_reg.win_sel != wwd_pkg::WIN_OPEN_FULL) &&
                         (count_reg < win_closed);
  wire logic kick_ev = running && KICK_WR_I;
  wire logic key_ok = (KICK_WDATA_I == wwd_pkg::KICK_KEY);
  wire logic kick_good = kick_ev && !KICK_BIT_OP_I && key_ok &&
                         (!kicked_reg || !in_closed);
  wire logic ovf_hit = tick && (count_reg == ovf_limit);
  wire logic exempt = (ACCESS_ADDR_I >= wwd_pkg::EXEMPT_A_LO &&
                       ACCESS_ADDR_I <= wwd_pkg::EXEMPT_A_HI) ||
                      (ACCESS_ADDR_I >= wwd_pkg::EXEMPT_B_LO);
  wire logic fetch_ok = area_ok(FETCH_ADDR_I, INTERNAL_MEMORY_SIZE_I,
                                EXPANSION_RAM_SIZE_I);
  wire logic acc_ok = area_ok(ACCESS_ADDR_I, INTERNAL_MEMORY_SIZE_I,
                              EXPANSION_RAM_SIZE_I);
  wwd_pkg::wwd_cause_s cause_now;

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  assign cause_now.overflow = ovf_hit && !kick_good;
  assign cause_now.window = kick_ev && !KICK_BIT_OP_I && key_ok &&
                            kicked_reg && in_closed;
  assign cause_now.bit_op = kick_ev && KICK_BIT_OP_I;
  assign cause_now.bad_key = kick_ev && !KICK_BIT_OP_I && !key_ok;
  assign cause_now.fetch = running && FETCH_I && !fetch_ok;
  assign cause_now.access = running && ACCESS_I && !exempt &&
                            !acc_ok;
  wire logic any_cause = |cause_now;

  wwd_tick_div u_tick (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .run_i(running),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wwd_pkg::WWD_ST_CFG: begin
        state_next = OPTION_BYTE_I[wwd_pkg::OPT_EN_BIT] ?
                     wwd_pkg::WWD_ST_RUN : wwd_pkg::WWD_ST_OFF;
      end
      wwd_pkg::WWD_ST_RUN: begin
        if (any_cause) begin
          state_next = wwd_pkg::WWD_ST_HIT;
        end
      end
      default: state_next = state_reg;
    endcase
  end

  always_comb begin
    count_next = count_reg;
    if (kick_good) begin
      count_next = 16'h0000;
    end else if (tick && count_reg != wwd_pkg::COUNT_MAX) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= wwd_pkg::WWD_ST_CFG;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == wwd_pkg::WWD_ST_CFG) begin
        cfg_reg.enable <= OPTION_BYTE_I[wwd_pkg::OPT_EN_BIT];
        cfg_reg.ovf_sel <= OPTION_BYTE_I[wwd_pkg::OPT_OVF_LSB +: 3];
        cfg_reg.win_sel <= OPTION_BYTE_I[wwd_pkg::OPT_WIN_LSB +: 2];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      count_reg <= 16'h0000;
      kicked_reg <= 1'b0;
    end else if (running) begin
      count_reg <= count_next;
      kicked_reg <= kicked_reg || kick_good;
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      req_reg <= 1'b0;
      cause_reg <= '0;
    end else begin
      req_reg <= running && any_cause;
      if (running && any_cause) begin
        cause_reg <= cause_now;
      end
    end
  end

  assign INT_RESET_REQ_O = req_reg;
  assign RESET_CAUSE_O = cause_reg;
  assign RUNNING_O = running;
  assign COUNT_O = count_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ENABLE_PICK: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (state_reg == wwd_pkg::WWD_ST_CFG) |=>
      (RUNNING_O == $past(OPTION_BYTE_I[wwd_pkg::OPT_EN_BIT])))
    else $error("enable option not followed");
  AST_DISABLED_QUIET: assert property (@(posedge CLOCK_I)
    disable iff (!ARST_N_I)
    (state_reg == wwd_pkg::WWD_ST_OFF) |-> !cfg_reg.enable ##1
      !INT_RESET_REQ_O)
    else $error("request while disabled");
  AST_KICK_CLEARS: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    kick_good |=> (COUNT_O == 16'h0000) && !INT_RESET_REQ_O)
    else $error("good kick did not clear");
  AST_WINDOW_RESET: assert property (@(posedge CLOCK_I)
    disable iff (!ARST_N_I)
    (kick_ev && key_ok && !KICK_BIT_OP_I && kicked_reg && in_closed) |=>
      INT_RESET_REQ_O && RESET_CAUSE_O.window)
    else $error("closed window kick missed");
  AST_FIRST_KICK: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (kick_ev && key_ok && !KICK_BIT_OP_I && !kicked_reg) |=>
      kicked_reg && !INT_RESET_REQ_O)
    else $error("first kick refused");
  AST_OVERFLOW: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (running && tick && COUNT_O == ovf_limit && !KICK_WR_I) |=>
      INT_RESET_REQ_O && RESET_CAUSE_O.overflow)
    else $error("overflow missed");
  AST_BIT_OP: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (kick_ev && KICK_BIT_OP_I) |=> INT_RESET_REQ_O && RESET_CAUSE_O.bit_op)
    else $error("bit op missed");
  AST_BAD_KEY: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (kick_ev && !KICK_BIT_OP_I && KICK_WDATA_I != wwd_pkg::KICK_KEY) |=>
      INT_RESET_REQ_O && RESET_CAUSE_O.bad_key)
    else $error("bad key missed");
  AST_FETCH: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (running && FETCH_I && !fetch_ok) |=> RESET_CAUSE_O.fetch)
    else $error("bad fetch missed");
  AST_EXEMPT: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (running && ACCESS_I && ACCESS_ADDR_I >= wwd_pkg::EXEMPT_B_LO &&
     !FETCH_I && !KICK_WR_I && !tick) |=> !INT_RESET_REQ_O)
    else $error("exempt access reset");
  AST_PULSE: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    INT_RESET_REQ_O |=> !INT_RESET_REQ_O [*2])
    else $error("request not one cycle");
  AST_COUNT_STEP: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (running && !tick && !kick_good) |=> $stable(COUNT_O))
    else $error("count moved without tick");

endmodule : wwd_top
`default_nettype wire

// ### tb/wwd_cpu_model.sv
/*
  CPU side model: issues one-cycle kick writes, fetches and data accesses.
  Assumes the bench calls op from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_cpu_model (
  input wire logic clk_i,
  output logic kick_wr_o,
  output logic [7:0] kick_wdata_o,
  output logic kick_bit_op_o,
  output logic fetch_o,
  output logic [15:0] fetch_addr_o,
  output logic access_o,
  output logic [15:0] access_addr_o
);
  // ------
  // Strobes
  // ------
  initial begin
    kick_wr_o = 1'b0;
    kick_wdata_o = 8'h00;
    kick_bit_op_o = 1'b0;
    fetch_o = 1'b0;
    fetch_addr_o = 16'h0000;
    access_o = 1'b0;
    access_addr_o = 16'h0000;
  end

  // Kind 0 kick, 1 fetch, 2 access; idle data and address lines show the inverted value
  task automatic op(input int kind, input logic [7:0] d, input logic b,
                    input logic [15:0] a);
    @(posedge clk_i);
    kick_wr_o <= (kind == 0);
    kick_wdata_o <= d;
    kick_bit_op_o <= b;
    fetch_o <= (kind == 1);
    fetch_addr_o <= a;
    access_o <= (kind == 2);
    access_addr_o <= a;
    @(posedge clk_i);
    kick_wr_o <= 1'b0;
    kick_wdata_o <= ~d;
    kick_bit_op_o <= 1'b0;
    fetch_o <= 1'b0;
    fetch_addr_o <= ~a;
    access_o <= 1'b0;
    access_addr_o <= ~a;
  endtask : op
endmodule : wwd_cpu_model
`default_nettype wire

// ### tb/wwd_top_test.sv
/*
  Self-checking bench of the watchdog: kicks, window, address checks.
  Assumes the CPU model drives all strobes; each trial reboots the block.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top_test;
  localparam logic [15:0] CORNER [0:4] = '{16'hfb00, 16'hffcf, 16'hffd0,
    16'hffe0, 16'hffff};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] opt = 8'h00;
  logic [7:0] internal_memory_size_reg = 8'h00;
  logic [7:0] expansion_ram_size_reg = 8'h00;
  logic kwr, kbit, fe, ac, req, run;
  logic [7:0] kd;
  logic [15:0] fa, aa, cnt;
  wwd_pkg::wwd_cause_s cause;
  int bad_count = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  wwd_cpu_model i_cpu (.clk_i(clk), .kick_wr_o(kwr), .kick_wdata_o(kd),
    .kick_bit_op_o(kbit), .fetch_o(fe), .fetch_addr_o(fa), .access_o(ac),
    .access_addr_o(aa));
  wwd_top i_dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .OPTION_BYTE_I(opt),
    .KICK_WR_I(kwr), .KICK_WDATA_I(kd), .KICK_BIT_OP_I(kbit),
    .FETCH_I(fe), .FETCH_ADDR_I(fa), .ACCESS_I(ac), .ACCESS_ADDR_I(aa),
    .INTERNAL_MEMORY_SIZE_I(internal_memory_size_reg), .EXPANSION_RAM_SIZE_I(expansion_ram_size_reg),
    .INT_RESET_REQ_O(req), .RESET_CAUSE_O(cause), .RUNNING_O(run),
    .COUNT_O(cnt));

  // ------
  // Helpers
  // ------
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  function automatic logic legal(input logic [15:0] a, input logic acc,
                                 input logic [7:0] m, input logic [7:0] x);
    logic [16:0] top;
    top = 17'hf000 + {x[3:0], 10'h000};
    return (a <= {m[3:0], 12'hfff}) ||
      ({1'b0, a} + {m[7:4], 8'h00} >= 17'hff00 && a <= 16'hfeff) ||
      (a >= 16'hf000 && {1'b0, a} < top) ||
      (acc && ((a >= 16'hfb00 && a <= 16'hffcf) || a >= 16'hffe0));
  endfunction : legal

  task automatic boot(input logic [7:0] o);
    @(posedge clk);
    arst_n <= 1'b0;
    opt <= o;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8 && (i < 3 || run !== o[4]); i++) begin
      @(posedge clk);
      #1;
    end
  endtask : boot

  task automatic trial(input logic [7:0] o, input int k, input logic [7:0] d,
    input logic b, input logic [15:0] a, input logic er, input logic [5:0] ec);
    boot(o);
    i_cpu.op(k, d, b, a);
    #1;
    cmp({15'h0, er}, {15'h0, req});
    cmp({10'h0, ec}, {10'h0, cause});
    @(posedge clk);
    #1;
    cmp(16'h0000, {15'h0, req});
    $display("trial kind %0d done at %0t", k, $time);
  endtask : trial

  // ------
  // Sequence
  // ------
  initial begin
    logic [15:0] a;
    logic [7:0] m, x;
    logic l;
    int k;
    void'($urandom(58811));
    trial(8'h00, 0, 8'h55, 1'b0, 16'h0000, 1'b0, 6'h00);
    cmp(16'h0000, {15'h0, run});
    trial({1'b0, 2'($urandom), 1'b1, 3'($urandom), 1'b0}, 0,
      8'hac ^ 8'($urandom_range(1, 255)), 1'b0, 16'h0000,
      1'b1, 6'h04);
    trial(8'h10, 0, 8'hac, 1'b1, 16'h0000, 1'b1, 6'h08);
    for (int i = 0; i < 34; i++) begin
      m = 8'($urandom);
      x = 8'($urandom);
      @(posedge clk);
      internal_memory_size_reg <= m;
      expansion_ram_size_reg <= x;
      a = i < 10 ? CORNER[i / 2] :
        (i % 4 < 2 ? 16'($urandom_range(0, {m[3:0], 12'hfff})) : 16'($urandom));
      k = 1 + i % 2;
      l = legal(a, k == 2, m, x);
      trial(8'h10, k, 8'h00, 1'b0, a, !l,
        l ? 6'h00 : (k == 1 ? 6'h02 : 6'h01));
    end
    for (int w = 0; w < 4; w++) begin
      boot({1'b0, 2'(w), 1'b1, 3'($urandom), 1'b0});
      repeat (2 * 833 + 400) @(posedge clk);
      #1;
      cmp(16'h0002, cnt);
      i_cpu.op(0, 8'hac, 1'b0, 16'h0000);
      #1;
      cmp(16'h0000, cnt);
      cmp(16'h0000, {15'h0, req});
      i_cpu.op(0, 8'hac, 1'b0, 16'h0000);
      #1;
      cmp({15'h0, w != 3}, {15'h0, req});
      cmp({10'h0, w == 3 ? 6'h00 : 6'h10}, {10'h0, cause});
      $display("window test %0d done at %0t", w, $time);
    end
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule : wwd_top_test
`default_nettype wire
